// ### hw/ssf_consts.svh
// Offsets, field positions, reset values and timing counts of the serial status block
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH
`define SSF_ADDR_W 24
`define SSF_ADR_CTRL 24'hFFF602
`define SSF_ADR_TXH 24'hFFF603
`define SSF_ADR_STAT 24'hFFF604
`define SSF_ADR_RXH 24'hFFF605
`define SSF_ADR_CARD 24'hFFF606
`define SSF_ADR_EXT 24'hFFF608
// Flag vector index; status register bit is index plus SSF_STAT_SHIFT
`define SSF_F_TXE 5
`define SSF_F_RXF 4
`define SSF_F_OVR 3
`define SSF_F_FRM 2
`define SSF_F_PRTY 1
`define SSF_F_TXEND 0
`define SSF_STAT_SHIFT 2
`define SSF_F_WRITABLE 6'h3E
// serial_control fields
`define SSF_C_TXIE 7
`define SSF_C_RXIE 6
`define SSF_C_TXON 5
`define SSF_C_RXON 4
`define SSF_C_PAR 0
// card_mode_control field
`define SSF_M_CARD 0
`define SSF_CTRL_RST 8'h00
`define SSF_CARD_RST 8'h00
`define SSF_EXT_RST 8'h00
`define SSF_FLG_RST 6'h21
// Bit timing
`define SSF_CLK_HZ 25000000
`define SSF_BAUD_BPS 115200
`define SSF_BIT_CYC (`SSF_CLK_HZ / `SSF_BAUD_BPS)
`define SSF_HALF_CYC (`SSF_BIT_CYC / 2)
`endif

// ### hw/ssf_pkg.sv
// Types shared by the serial status block modules
`default_nettype none
package ssf_pkg;
    typedef enum logic [2:0] {
        SSF_RX_IDLE = 3'h1,
        SSF_RX_START = 3'h2,
        SSF_RX_BITS = 3'h4
    } ssf_rx_e;
    typedef enum logic [1:0] {
        SSF_TX_IDLE = 2'h1,
        SSF_TX_SHIFT = 2'h2
    } ssf_tx_e;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] card;
        logic [7:0] ext;
        logic [7:0] txh;
        logic [7:0] rxh;
        logic [7:0] rdata;
        logic [5:0] flg;
        logic [5:0] armed;
        logic tx_start;
        logic [7:0] tx_data;
        ssf_rx_e rx_st;
        logic [7:0] rx_cnt;
        logic [3:0] rx_idx;
        logic [9:0] rx_sh;
        logic irq_txe;
        logic irq_rxf;
        logic irq_err;
    } ssf_top_s;
    typedef struct packed {
        ssf_tx_e st;
        logic [7:0] cnt;
        logic [3:0] idx;
        logic [10:0] sh;
        logic txd;
        logic last;
    } ssf_tx_s;
endpackage
`default_nettype wire

// ### hw/ssf_tx_if.sv
// Handshake between the status logic and the transmit shifter
`timescale 1ns/1ns
`default_nettype none
interface ssf_tx_if;
    logic start;
    logic en;
    logic par_en;
    logic [7:0] data;
    logic busy;
    logic last;
    logic txd;
    modport ctl(output start, en, par_en, data, input busy, last, txd);
    modport eng(input start, en, par_en, data, output busy, last, txd);
endinterface
`default_nettype wire

// ### hw/ssf_tx.sv
// Transmit shift register: start, 8 data, optional even parity, stop
`timescale 1ns/1ns
`default_nettype none
`include "ssf_consts.svh"
module ssf_tx (
    input wire logic i_clk, // System clock
    input wire logic i_rst, // Async reset, high
    ssf_tx_if.eng tx // Link to status logic
);
    ssf_pkg::ssf_tx_s q;
    ssf_pkg::ssf_tx_s n;
    logic [3:0] last_idx;

    assign tx.busy = (q.st == ssf_pkg::SSF_TX_SHIFT);
    assign tx.last = q.last;
    assign tx.txd = q.txd;

    always_comb begin
        n = q;
        n.last = 1'b0;
        last_idx = tx.par_en ? 4'hA : 4'h9;
        unique case (q.st)
            ssf_pkg::SSF_TX_IDLE: begin
                if (tx.start && tx.en) begin
                    n.st = ssf_pkg::SSF_TX_SHIFT;
                    n.sh = {1'b1, tx.par_en ? ^tx.data : 1'b1, tx.data, 1'b0};
                    n.txd = 1'b0;
                    n.cnt = 8'(`SSF_BIT_CYC - 1);
                    n.idx = 4'h0;
                end
            end
            ssf_pkg::SSF_TX_SHIFT: begin
                // Dropping the enable aborts the character at once
                if (!tx.en) begin
                    n.st = ssf_pkg::SSF_TX_IDLE;
                    n.txd = 1'b1;
                end else if (q.cnt != 8'h00) begin
                    n.cnt = q.cnt - 8'h01;
                end else if (q.idx == last_idx) begin
                    n.st = ssf_pkg::SSF_TX_IDLE;
                    n.txd = 1'b1;
                    n.last = 1'b1;
                end else begin
                    n.sh = {1'b1, q.sh[10:1]};
                    n.txd = q.sh[1];
                    n.cnt = 8'(`SSF_BIT_CYC - 1);
                    n.idx = q.idx + 4'h1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '{st: ssf_pkg::SSF_TX_IDLE, cnt: 8'h00, idx: 4'h0, sh: 11'h7FF, txd: 1'b1, last: 1'b0};
        end else begin
            q <= n;
        end
    end
endmodule
`default_nettype wire

// ### hw/ssf_top.sv
// Status flags, control registers and receiver of one serial channel
`timescale 1ns/1ns
`default_nettype none
`include "ssf_consts.svh"
module ssf_top (
    input wire logic i_clk, // System clock, 25 MHz
    input wire logic i_rst, // Async reset, high
    input wire logic [23:0] i_addr, // Register address
    input wire logic [7:0] i_wdata, // Register write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [7:0] o_rdata, // Read data, cycle after strobe
    input wire logic i_dma_tx_wr, // DMA writes transmit holding
    input wire logic [7:0] i_dma_tx_data, // DMA transmit byte
    input wire logic i_dma_rx_rd, // DMA reads receive holding
    output logic [7:0] o_rx_holding, // Receive holding contents
    input wire logic i_rxd, // Serial input, idle high
    output logic o_txd, // Serial output, idle high
    output logic o_tx_empty_irq, // Holding-empty request
    output logic o_rx_full_irq, // Receive-full request
    output logic o_rx_error_irq, // Receive-error request
    output logic o_card_mode // Smart card mode active
);
    function automatic logic hit(input logic [23:0] a, input logic [23:0] r);
        return a == r;
    endfunction

    function automatic ssf_pkg::ssf_top_s rst_val();
        ssf_pkg::ssf_top_s s;
        s = '0;
        s.ctrl = `SSF_CTRL_RST;
        s.card = `SSF_CARD_RST;
        s.ext = `SSF_EXT_RST;
        s.flg = `SSF_FLG_RST;
        s.rx_st = ssf_pkg::SSF_RX_IDLE;
        return s;
    endfunction

    localparam ssf_pkg::ssf_top_s RST = rst_val();

    ssf_pkg::ssf_top_s q;
    ssf_pkg::ssf_top_s n;
    ssf_tx_if tx();

    logic tx_on;
    logic rx_on;
    logic par;
    logic [3:0] rx_last;
    logic [9:0] frame;
    logic [7:0] rdat;
    logic ferr;
    logic perr;

    ssf_tx u_tx (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .tx(tx.eng)
    );

    assign tx.start = q.tx_start;
    assign tx.data = q.tx_data;
    assign tx.en = q.ctrl[`SSF_C_TXON];
    // Smart card framing always carries parity
    assign tx.par_en = q.ctrl[`SSF_C_PAR] | q.card[`SSF_M_CARD];

    assign o_rdata = q.rdata;
    assign o_rx_holding = q.rxh;
    assign o_txd = tx.txd;
    assign o_tx_empty_irq = q.irq_txe;
    assign o_rx_full_irq = q.irq_rxf;
    assign o_rx_error_irq = q.irq_err;
    assign o_card_mode = q.card[`SSF_M_CARD];

    always_comb begin
        n = q;
        n.tx_start = 1'b0;
        n.rdata = 8'h00;
        tx_on = q.ctrl[`SSF_C_TXON];
        rx_on = q.ctrl[`SSF_C_RXON];
        par = q.ctrl[`SSF_C_PAR] | q.card[`SSF_M_CARD];
        rx_last = par ? 4'h9 : 4'h8;
        frame = {i_rxd, q.rx_sh[9:1]};
        rdat = par ? frame[7:0] : frame[8:1];
        ferr = !frame[9];
        perr = par && (^frame[8:0]);

        // Register writes; clears come first so any set below wins
        if (i_wr) begin
            if (hit(i_addr, `SSF_ADR_CTRL)) begin
                n.ctrl = i_wdata;
            end
            if (hit(i_addr, `SSF_ADR_TXH)) begin
                n.txh = i_wdata;
            end
            if (hit(i_addr, `SSF_ADR_CARD)) begin
                n.card = i_wdata;
            end
            if (hit(i_addr, `SSF_ADR_EXT)) begin
                n.ext = i_wdata;
            end
            if (hit(i_addr, `SSF_ADR_STAT)) begin
                // A zero only clears a flag that was seen as one
                for (int i = 1; i < 6; i++) begin
                    if (!i_wdata[i + `SSF_STAT_SHIFT] && q.armed[i]) begin
                        n.flg[i] = 1'b0;
                        n.armed[i] = 1'b0;
                    end
                end
            end
        end

        if (i_rd) begin
            if (hit(i_addr, `SSF_ADR_CTRL)) begin
                n.rdata = q.ctrl;
            end
            if (hit(i_addr, `SSF_ADR_TXH)) begin
                n.rdata = q.txh;
            end
            if (hit(i_addr, `SSF_ADR_STAT)) begin
                n.rdata = {q.flg, 2'b00};
                n.armed = q.flg & `SSF_F_WRITABLE;
            end
            if (hit(i_addr, `SSF_ADR_RXH)) begin
                n.rdata = q.rxh;
            end
            if (hit(i_addr, `SSF_ADR_CARD)) begin
                n.rdata = q.card;
            end
            if (hit(i_addr, `SSF_ADR_EXT)) begin
                n.rdata = q.ext;
            end
        end

        // DMA service counts as flag clearing only when the request stands
        if (i_dma_tx_wr) begin
            n.txh = i_dma_tx_data;
            if (q.irq_txe) begin
                n.flg[`SSF_F_TXE] = 1'b0;
                n.flg[`SSF_F_TXEND] = 1'b0;
            end
        end
        if (i_dma_rx_rd && q.irq_rxf) begin
            n.flg[`SSF_F_RXF] = 1'b0;
        end

        // Holding byte moves to the shifter once the shifter is free
        if (tx_on && !q.flg[`SSF_F_TXE] && !tx.busy && !q.tx_start) begin
            n.tx_start = 1'b1;
            n.tx_data = q.txh;
            n.flg[`SSF_F_TXE] = 1'b1;
        end
        if (tx.last && q.flg[`SSF_F_TXE]) begin
            n.flg[`SSF_F_TXEND] = 1'b1;
        end
        if (!tx_on) begin
            n.flg[`SSF_F_TXE] = 1'b1;
            n.flg[`SSF_F_TXEND] = 1'b1;
        end

        // Receiver; an abort never touches the receive-full flag
        unique case (q.rx_st)
            ssf_pkg::SSF_RX_IDLE: begin
                if (rx_on && !i_rxd) begin
                    n.rx_st = ssf_pkg::SSF_RX_START;
                    n.rx_cnt = 8'(`SSF_HALF_CYC);
                end
            end
            ssf_pkg::SSF_RX_START: begin
                if (!rx_on) begin
                    n.rx_st = ssf_pkg::SSF_RX_IDLE;
                end else if (q.rx_cnt != 8'h00) begin
                    n.rx_cnt = q.rx_cnt - 8'h01;
                end else if (i_rxd) begin
                    // Start bit gone at mid-bit: treat as a glitch
                    n.rx_st = ssf_pkg::SSF_RX_IDLE;
                end else begin
                    n.rx_st = ssf_pkg::SSF_RX_BITS;
                    n.rx_cnt = 8'(`SSF_BIT_CYC - 1);
                    n.rx_idx = 4'h0;
                end
            end
            ssf_pkg::SSF_RX_BITS: begin
                if (!rx_on) begin
                    n.rx_st = ssf_pkg::SSF_RX_IDLE;
                end else if (q.rx_cnt != 8'h00) begin
                    n.rx_cnt = q.rx_cnt - 8'h01;
                end else begin
                    n.rx_sh = frame;
                    n.rx_cnt = 8'(`SSF_BIT_CYC - 1);
                    n.rx_idx = q.rx_idx + 4'h1;
                    if (q.rx_idx == rx_last) begin
                        n.rx_st = ssf_pkg::SSF_RX_IDLE;
                        if (ferr) begin
                            n.flg[`SSF_F_FRM] = 1'b1;
                        end
                        if (perr) begin
                            n.flg[`SSF_F_PRTY] = 1'b1;
                        end
                        if (q.flg[`SSF_F_RXF]) begin
                            n.flg[`SSF_F_OVR] = 1'b1;
                        end else if (!ferr && !perr) begin
                            n.rxh = rdat;
                            n.flg[`SSF_F_RXF] = 1'b1;
                        end
                    end
                end
            end
        endcase

        n.irq_txe = n.ctrl[`SSF_C_TXIE] & n.flg[`SSF_F_TXE];
        n.irq_rxf = n.ctrl[`SSF_C_RXIE] & n.flg[`SSF_F_RXF];
        n.irq_err = n.ctrl[`SSF_C_RXIE] & (|n.flg[`SSF_F_OVR:`SSF_F_PRTY]);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= RST;
        end else begin
            q <= n;
        end
    end
endmodule
`default_nettype wire

// ### bench/ssf_top_props.sv
// Port-level assertions for the serial status block
`timescale 1ns/1ns
`default_nettype none
`include "ssf_consts.svh"
module ssf_top_props (
    input wire logic i_clk, // Clock
    input wire logic i_rst, // Reset
    input wire logic [23:0] i_addr, // Address
    input wire logic [7:0] i_wdata, // Write data
    input wire logic i_wr, // Write
    input wire logic i_rd, // Read
    input wire logic [7:0] o_rdata, // Read data
    input wire logic i_dma_tx_wr, // DMA load
    input wire logic i_dma_rx_rd, // DMA fetch
    input wire logic o_tx_empty_irq, // Tx request
    input wire logic o_rx_full_irq, // Rx request
    input wire logic o_rx_error_irq, // Error request
    input wire logic o_card_mode // Card mode
);
    logic [7:0] ctl_q;
    logic wc;
    logic ws;
    assign wc = i_wr && i_addr == `SSF_ADR_CTRL;
    assign ws = i_wr && i_addr == `SSF_ADR_STAT;
    // Mirror of serial_control, so enables can be read at the ports
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) ctl_q <= 8'h00;
        else if (wc) ctl_q <= i_wdata;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_tx_gate; wc && !i_wdata[7] |=> !o_tx_empty_irq; endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx request while disabled");
    property p_rx_gate; wc && !i_wdata[6] |=> !o_rx_full_irq && !o_rx_error_irq; endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx request while disabled");
    property p_card; i_wr && i_addr == `SSF_ADR_CARD |=> o_card_mode == $past(i_wdata[0]); endproperty
    a_card: assert property (p_card) else $error("card mode not following write");
    // A control write in the same cycle may drop the enable, so it is left out
    property p_te_off; ctl_q[7] && !ctl_q[5] && !wc |=> o_tx_empty_irq; endproperty
    a_te_off: assert property (p_te_off) else $error("holding empty not set with tx off");
    property p_dma_tx; i_dma_tx_wr && o_tx_empty_irq && ctl_q[5] && !i_wr |=> !o_tx_empty_irq; endproperty
    a_dma_tx: assert property (p_dma_tx) else $error("dma load did not clear empty");
    property p_dma_rx; i_dma_rx_rd && o_rx_full_irq |=> !o_rx_full_irq; endproperty
    a_dma_rx: assert property (p_dma_rx) else $error("dma fetch did not clear full");
    property p_err_hold; o_rx_error_irq && !ws && !wc |=> o_rx_error_irq; endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag cleared without write");
    property p_stat_rd;
        i_rd && i_addr == `SSF_ADR_STAT |=> o_rdata[1:0] == 2'h0 &&
            (!ctl_q[7] || o_rdata[7] == $past(o_tx_empty_irq)) &&
            (!ctl_q[6] || (|o_rdata[5:3]) == $past(o_rx_error_irq));
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status read disagrees with requests");
    property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    c_err: cover property (o_rx_error_irq);
    c_dma: cover property (i_dma_tx_wr && o_tx_empty_irq);
    c_card: cover property (o_card_mode);
endmodule
bind ssf_top ssf_top_props i_props (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_dma_tx_wr(i_dma_tx_wr), .i_dma_rx_rd(i_dma_rx_rd),
    .o_tx_empty_irq(o_tx_empty_irq), .o_rx_full_irq(o_rx_full_irq), .o_rx_error_irq(o_rx_error_irq),
    .o_card_mode(o_card_mode));
`default_nettype wire

// ### bench/ssf_line.sv
// Remote serial partner: frame sender and frame decoder
`timescale 1ns/1ns
`default_nettype none
`include "ssf_consts.svh"
module ssf_line (
    input wire logic i_clk, // System clock
    input wire logic i_txd, // Block serial output
    output logic o_rxd // Block serial input
);
    logic [7:0] got;
    logic [7:0] b;
    int n_got = 0;
    initial o_rxd = 1'b1;
    task automatic put(input logic v);
        o_rxd <= v;
        repeat (`SSF_BIT_CYC) @(posedge i_clk);
    endtask
    // Faults only when a scenario asks for them
    task automatic send(input logic [7:0] d, input logic par, input logic bad_par, input logic bad_stop);
        @(posedge i_clk);
        put(1'b0);
        for (int i = 0; i < 8; i++) put(d[i]);
        if (par) put(^d ^ bad_par);
        put(!bad_stop);
        put(1'b1);
    endtask
    // Sample mid-bit; frames from the block carry no parity here
    always begin
        do @(posedge i_clk); while (i_txd !== 1'b0);
        repeat (`SSF_HALF_CYC) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (`SSF_BIT_CYC) @(posedge i_clk);
            b[i] = i_txd;
        end
        repeat (`SSF_BIT_CYC) @(posedge i_clk);
        got = b;
        n_got++;
    end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the serial status block
`timescale 1ns/1ns
`default_nettype none
`include "ssf_consts.svh"
module tb;
    localparam logic [23:0] st = `SSF_ADR_STAT;
    localparam logic [23:0] ct = `SSF_ADR_CTRL;
    logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_dma_tx_wr = 1'b0, i_dma_rx_rd = 1'b0;
    logic [23:0] i_addr = 24'h000000;
    logic [7:0] i_wdata = 8'h00, i_dma_tx_data = 8'h00, o_rdata, o_rx_holding;
    logic i_rxd, o_txd, o_tx_empty_irq, o_rx_full_irq, o_rx_error_irq, o_card_mode;
    int num_errors = 0, n_checks = 0, cyc = 0;
    always #20 i_clk = ~i_clk;
    ssf_top i_ssf_top (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_dma_tx_wr(i_dma_tx_wr), .i_dma_tx_data(i_dma_tx_data),
        .i_dma_rx_rd(i_dma_rx_rd), .o_rx_holding(o_rx_holding), .i_rxd(i_rxd), .o_txd(o_txd),
        .o_tx_empty_irq(o_tx_empty_irq), .o_rx_full_irq(o_rx_full_irq), .o_rx_error_irq(o_rx_error_irq),
        .o_card_mode(o_card_mode));
    ssf_line u_line (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(i_rxd));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [23:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    task automatic dma(input logic tx, input logic [7:0] d);
        @(posedge i_clk);
        i_dma_tx_data <= d;
        i_dma_tx_wr <= tx;
        i_dma_rx_rd <= !tx;
        @(posedge i_clk);
        i_dma_tx_wr <= 1'b0;
        i_dma_rx_rd <= 1'b0;
    endtask
    // Bounded wait for the partner to decode one frame
    task automatic wait_tx(input logic [7:0] e);
        int n0;
        int k;
        n0 = u_line.n_got;
        k = 0;
        while (u_line.n_got == n0 && k < 4000) begin
            @(posedge i_clk);
            k++;
        end
        chk(u_line.got, e);
    endtask
    task automatic t_reset;
        rchk(st, 8'h84);
        rchk(ct, 8'h00);
        wr(`SSF_ADR_EXT, 8'h5A);
        rchk(`SSF_ADR_EXT, 8'h5A);
        wr(24'hFFF60A, 8'hFF);
        rchk(24'hFFF60A, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_tx;
        wr(ct, 8'h20);
        wr(`SSF_ADR_TXH, 8'hA5);
        rchk(st, 8'h84);
        wr(st, 8'h7F);
        rchk(st, 8'h84);
        wait_tx(8'hA5);
        repeat (`SSF_BIT_CYC) @(posedge i_clk);
        rchk(st, 8'h84);
        $display("software transmit test done");
    endtask
    task automatic t_dma;
        wr(ct, 8'hA0);
        #1 chk({7'h00, o_tx_empty_irq}, 8'h01);
        dma(1'b1, 8'h81);
        rchk(st, 8'h80);
        dma(1'b1, 8'h55);
        rchk(st, 8'h00);
        wait_tx(8'h81);
        wr(ct, 8'h80);
        rchk(st, 8'h84);
        $display("dma transmit test done");
    endtask
    task automatic t_rx;
        wr(ct, 8'h50);
        u_line.send(8'h3C, 1'b0, 1'b0, 1'b0);
        chk(o_rx_holding, 8'h3C);
        chk({6'h00, o_rx_error_irq, o_rx_full_irq}, 8'h01);
        rchk(st, 8'hC4);
        u_line.send(8'h77, 1'b0, 1'b0, 1'b0);
        chk(o_rx_holding, 8'h3C);
        chk({6'h00, o_rx_error_irq, o_rx_full_irq}, 8'h03);
        rchk(st, 8'hE4);
        wr(st, 8'hFF);
        rchk(st, 8'hE4);
        wr(st, 8'hDF);
        rchk(st, 8'hC4);
        wr(ct, 8'h40);
        rchk(st, 8'hC4);
        wr(ct, 8'h50);
        dma(1'b0, 8'h00);
        rchk(st, 8'h84);
        $display("receive test done");
    endtask
    task automatic t_err;
        u_line.send(8'hA1, 1'b0, 1'b0, 1'b1);
        rchk(st, 8'h94);
        chk({6'h00, o_rx_error_irq, o_rx_full_irq}, 8'h02);
        wr(st, 8'hEF);
        rchk(st, 8'h84);
        wr(ct, 8'h51);
        u_line.send(8'h5A, 1'b1, 1'b1, 1'b0);
        rchk(st, 8'h8C);
        wr(st, 8'hF7);
        rchk(st, 8'h84);
        wr(ct, 8'h50);
        wr(`SSF_ADR_CARD, 8'h01);
        #1 chk({7'h00, o_card_mode}, 8'h01);
        u_line.send(8'h5A, 1'b1, 1'b0, 1'b0);
        rchk(st, 8'hC4);
        chk(o_rx_holding, 8'h5A);
        wr(`SSF_ADR_CARD, 8'h00);
        rchk(`SSF_ADR_CARD, 8'h00);
        $display("error and card test done");
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset;
        t_tx;
        t_dma;
        t_rx;
        t_err;
        wrap_up;
    end
    // Run needs about 17000 cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            wrap_up;
        end
    end
endmodule
`default_nettype wire
